// *** verilog/adcc_cfg.svh ***
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// =============================================================
// register indices (byte address is four times the index)
`define ADCC_IDX_PORT_A     8'h05
`define ADCC_IDX_INTCTL     8'h0b
`define ADCC_IDX_IRQ_FLAGS  8'h0c
`define ADCC_IDX_RESULT     8'h1e
`define ADCC_IDX_CTRL0      8'h1f
`define ADCC_IDX_PORT_DIR   8'h85
`define ADCC_IDX_IRQ_ENS    8'h8c
`define ADCC_IDX_PIN_CFG    8'h9f
`define ADCC_IDX_NONE       8'hff

// =============================================================
// field positions
`define ADCC_CTRL0_SEL_HI   7
`define ADCC_CTRL0_SEL_LO   6
`define ADCC_CTRL0_CHAN_HI  5
`define ADCC_CTRL0_CHAN_LO  3
`define ADCC_CTRL0_GO       2
`define ADCC_CTRL0_ON       0
`define ADCC_CONV_IRQ_BIT   6
`define ADCC_GIE_BIT        7
`define ADCC_PERIPHERAL_IRQ_ENABLE_BIT       6

// =============================================================
// reset values
`define ADCC_PORT_DIR_RST   6'h3f
`define ADCC_REG8_RST       8'h00

// =============================================================
// compare unit special event trigger mode
`define ADCC_CMP_TRIG_MODE  4'hb

// =============================================================
// timing: conversion is 9.5 bit periods = 19 half periods, sampling 1.5 periods
`define ADCC_CONV_HALVES    5'h13
`define ADCC_SAMPLE_HALVES  5'h03
// last count of the half-period divider for 2, 8 and 32 oscillator periods
`define ADCC_HALF_LAST_D2   4'h0
`define ADCC_HALF_LAST_D8   4'h3
`define ADCC_HALF_LAST_D32  4'hf

`endif

// *** verilog/adcc_pkg.sv ***
// types of the converter control block
`include "adcc_cfg.svh"

package adcc_pkg;

  // =============================================================
  // conversion clock select codes
  typedef enum logic [1:0] {
    ADCC_DIV2 = 2'h0,
    ADCC_DIV8 = 2'h1,
    ADCC_DIV32 = 2'h2,
    ADCC_RC = 2'h3
  } adcc_clk_sel_e;

  // =============================================================
  // bus slave data-phase states
  typedef enum logic [2:0] {
    ADCC_BUS_IDLE  = 3'h1,
    ADCC_BUS_WRITE = 3'h2,
    ADCC_BUS_RWAIT = 3'h4
  } adcc_bus_e;

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       s3;
    logic [3:0] cnt;
    logic       tick;
  } adcc_tick_s;

  typedef struct packed {
    adcc_bus_e     bus;
    logic          hreadyout;
    logic          hresp;
    logic [7:0]    dp_idx;
    logic [31:0]   hrdata;
    logic [5:0]    port_latch;
    logic [5:0]    port_oe;
    logic [7:0]    intctl;
    logic          irq_flag;
    logic          irq_en;
    adcc_clk_sel_e clk_sel;
    logic [2:0]    chan;
    logic          go;
    logic          on;
    logic [2:0]    pcfg;
    logic [7:0]    result;
    logic [4:0]    cnt;
    logic [7:0]    sar;
    logic [7:0]    mask;
    logic          timer_reset;
    logic          irq_request;
    logic          done;
  } adcc_state_s;

endpackage : adcc_pkg

// *** verilog/adcc_tick_gen.sv ***
// half-period tick generator for the conversion bit period
`include "adcc_cfg.svh"

module adcc_tick_gen (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire adcc_pkg::adcc_clk_sel_e clk_sel,
  input  wire logic                   run,
  input  wire logic                   rc_clk,
  output logic                        half_tick
);

  adcc_pkg::adcc_tick_s q;
  adcc_pkg::adcc_tick_s next_q;

  function automatic logic [3:0] half_last(input adcc_pkg::adcc_clk_sel_e sel);
    unique case (sel)
      adcc_pkg::ADCC_DIV2:  half_last = `ADCC_HALF_LAST_D2;
      adcc_pkg::ADCC_DIV8:  half_last = `ADCC_HALF_LAST_D8;
      adcc_pkg::ADCC_DIV32: half_last = `ADCC_HALF_LAST_D32;
      adcc_pkg::ADCC_RC:    half_last = `ADCC_HALF_LAST_D2;
    endcase
  endfunction : half_last

  // =============================================================
  // divider and rc synchroniser
  always_comb begin
    next_q    = q;
    next_q.s1 = rc_clk;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    if (!run) begin
      // restarting from zero makes every divided-clock conversion start on a full half period
      next_q.cnt  = 4'h0;
      next_q.tick = 1'b0;
    end else if (clk_sel == adcc_pkg::ADCC_RC) begin
      next_q.cnt  = 4'h0;
      next_q.tick = q.s2 ^ q.s3;
    end else if (q.cnt == half_last(clk_sel)) begin
      next_q.cnt  = 4'h0;
      next_q.tick = 1'b1;
    end else begin
      next_q.cnt  = q.cnt + 4'h1;
      next_q.tick = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign half_tick = q.tick;

  // =============================================================
  // checks
  a_div2_every_cycle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    run && clk_sel == adcc_pkg::ADCC_DIV2 |=> half_tick)
    else $error("half tick missing under divide by two");

  a_div8_tick_spacing: assert property (
    @(posedge hclk) disable iff (!hresetn)
    half_tick && run && clk_sel == adcc_pkg::ADCC_DIV8 |=> !half_tick[*3])
    else $error("half ticks too close under divide by eight");

endmodule : adcc_tick_gen

// *** verilog/adcc_top.sv ***
// converter control: ahb-lite register file, trigger handling and conversion sequencer
`include "adcc_cfg.svh"

module adcc_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [5:0]  port_a_in,
  output logic      [5:0]  port_a_out,
  output logic      [5:0]  port_a_oe,
  input  wire logic        rc_clk,
  input  wire logic [3:0]  compare_mode_field,
  input  wire logic        special_event_trig,
  output logic             timer_reset,
  output logic      [2:0]  conv_channel,
  output logic      [7:0]  sar_trial,
  input  wire logic        comp_above,
  output logic             conv_busy,
  output logic             irq_request
);

  adcc_pkg::adcc_state_s q;
  adcc_pkg::adcc_state_s next_q;
  logic                  half_tick;
  logic                  trig_hit;
  logic                  acc;
  logic                  hit;
  logic [7:0]            wd;
  logic [7:0]            sar_kept;
  logic [4:0]            cnt_n;

  // =============================================================
  // decoding helpers
  // pins that the pin configuration makes analog (voltage reference counted as analog)
  function automatic logic [5:0] analog_mask(input logic [2:0] pcfg);
    unique case (pcfg)
      3'h0, 3'h2: analog_mask = 6'h2f;
      3'h1, 3'h3: analog_mask = 6'h2f;
      3'h4:       analog_mask = 6'h0b;
      3'h5:       analog_mask = 6'h0b;
      default:    analog_mask = 6'h00;
    endcase
  endfunction : analog_mask

  function automatic logic [31:0] rd_mux(input adcc_pkg::adcc_state_s s,
                                          input logic [5:0]            pins);
    unique case (s.dp_idx)
      `ADCC_IDX_PORT_A:    rd_mux = {26'h0, pins & ~analog_mask(s.pcfg)};
      `ADCC_IDX_INTCTL:    rd_mux = {24'h0, s.intctl};
      `ADCC_IDX_IRQ_FLAGS: rd_mux = {24'h0, 1'b0, s.irq_flag, 6'h00};
      `ADCC_IDX_RESULT:    rd_mux = {24'h0, s.result};
      `ADCC_IDX_CTRL0:     rd_mux = {24'h0, s.clk_sel, s.chan, s.go, 1'b0, s.on};
      `ADCC_IDX_PORT_DIR:  rd_mux = {26'h0, ~s.port_oe};
      `ADCC_IDX_IRQ_ENS:   rd_mux = {24'h0, 1'b0, s.irq_en, 6'h00};
      `ADCC_IDX_PIN_CFG:   rd_mux = {29'h0, s.pcfg};
      default:             rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  adcc_tick_gen u_tick (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_sel   (q.clk_sel),
    .run       (q.go),
    .rc_clk    (rc_clk),
    .half_tick (half_tick)
  );

  // =============================================================
  // next state
  always_comb begin
    next_q             = q;
    wd                 = hwdata[7:0];
    acc                = hsel && htrans[1] && hready;
    hit                = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    trig_hit           = special_event_trig && (compare_mode_field == `ADCC_CMP_TRIG_MODE);
    sar_kept           = comp_above ? q.sar : (q.sar & ~q.mask);
    cnt_n              = q.cnt + 5'h01;
    next_q.done        = 1'b0;
    next_q.timer_reset = trig_hit;

    // bus: writes take effect in their data phase, reads get one wait state so
    // that a write just before is already visible
    next_q.bus       = adcc_pkg::ADCC_BUS_IDLE;
    next_q.hreadyout = 1'b1;
    if (q.bus == adcc_pkg::ADCC_BUS_RWAIT) begin
      next_q.hrdata = rd_mux(q, port_a_in);
    end
    if (acc) begin
      next_q.dp_idx = hit ? haddr[9:2] : `ADCC_IDX_NONE;
      if (hwrite) begin
        next_q.bus = adcc_pkg::ADCC_BUS_WRITE;
      end else begin
        next_q.bus       = adcc_pkg::ADCC_BUS_RWAIT;
        next_q.hreadyout = 1'b0;
      end
    end

    if (q.bus == adcc_pkg::ADCC_BUS_WRITE) begin
      unique case (q.dp_idx)
        `ADCC_IDX_PORT_A:    next_q.port_latch = wd[5:0];
        `ADCC_IDX_INTCTL:    next_q.intctl = wd;
        `ADCC_IDX_IRQ_FLAGS: next_q.irq_flag = wd[`ADCC_CONV_IRQ_BIT];
        `ADCC_IDX_CTRL0: begin
          next_q.clk_sel = adcc_pkg::adcc_clk_sel_e'(wd[`ADCC_CTRL0_SEL_HI:`ADCC_CTRL0_SEL_LO]);
          next_q.chan    = wd[`ADCC_CTRL0_CHAN_HI:`ADCC_CTRL0_CHAN_LO];
          next_q.on      = wd[`ADCC_CTRL0_ON];
          // start only counts when the converter was already on before this write
          if (!wd[`ADCC_CTRL0_GO] || !wd[`ADCC_CTRL0_ON]) begin
            next_q.go = 1'b0;
          end else if (q.on) begin
            next_q.go = 1'b1;
          end
        end
        `ADCC_IDX_PORT_DIR:  next_q.port_oe = ~wd[5:0];
        `ADCC_IDX_IRQ_ENS:   next_q.irq_en = wd[`ADCC_CONV_IRQ_BIT];
        `ADCC_IDX_PIN_CFG:   next_q.pcfg = wd[2:0];
        default: begin
        end
      endcase
    end

    // trigger start is not gated by channel or pin direction
    if (trig_hit && next_q.on) begin
      next_q.go = 1'b1;
    end

    // sequencer: 3 sampling half periods, then two half periods per result bit
    if (!q.go) begin
      next_q.cnt  = 5'h00;
      next_q.sar  = 8'h00;
      next_q.mask = 8'h00;
    end else if (!next_q.go) begin
      next_q.cnt = 5'h00;
    end else if (half_tick) begin
      next_q.cnt = cnt_n;
      if (cnt_n == `ADCC_SAMPLE_HALVES) begin
        next_q.mask = 8'h80;
        next_q.sar  = 8'h80;
      end else if (cnt_n > `ADCC_SAMPLE_HALVES && cnt_n[0]) begin
        next_q.mask = q.mask >> 1;
        next_q.sar  = sar_kept | (q.mask >> 1);
        if (cnt_n == `ADCC_CONV_HALVES) begin
          next_q.result = sar_kept;
          next_q.go     = 1'b0;
          next_q.cnt    = 5'h00;
          next_q.done   = 1'b1;
        end
      end
    end

    // completion sets the flag even against a clearing write in the same cycle
    if (next_q.done) begin
      next_q.irq_flag = 1'b1;
    end
    next_q.irq_request = next_q.irq_flag && next_q.irq_en
                         && next_q.intctl[`ADCC_PERIPHERAL_IRQ_ENABLE_BIT] && next_q.intctl[`ADCC_GIE_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q           <= '0;
      q.bus       <= adcc_pkg::ADCC_BUS_IDLE;
      q.hreadyout <= 1'b1;
      q.clk_sel   <= adcc_pkg::ADCC_DIV2;
      q.intctl    <= `ADCC_REG8_RST;
      q.port_oe   <= ~`ADCC_PORT_DIR_RST;
      q.dp_idx    <= `ADCC_IDX_NONE;
    end else begin
      q <= next_q;
    end
  end

  // =============================================================
  // outputs
  assign hrdata       = q.hrdata;
  assign hreadyout    = q.hreadyout;
  assign hresp        = q.hresp;
  assign port_a_out   = q.port_latch;
  // the channel mux sees the pin itself, so a driven pin converts its own level
  assign port_a_oe    = q.port_oe;
  assign conv_channel = q.chan;
  assign sar_trial    = q.sar;
  assign conv_busy    = q.go;
  assign timer_reset  = q.timer_reset;
  assign irq_request  = q.irq_request;

  // =============================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_done_sets_flag: assert property (
    q.done |-> q.irq_flag && !q.go)
    else $error("completion did not set flag and clear start");

  a_result_on_done: assert property (
    $changed(q.result) |-> q.done)
    else $error("result changed outside completion");

  a_conv_halves: assert property (
    q.done |-> $past(q.cnt) == 5'h12 && $past(half_tick))
    else $error("conversion did not last nineteen half periods");

  a_div2_conv_time: assert property (
    $rose(q.go) && q.clk_sel == adcc_pkg::ADCC_DIV2 |-> ##20 !q.go)
    else $error("divide by two conversion not done after twenty cycles");

  // the converter is judged on after a same-cycle write, as the start logic does
  a_trig_starts: assert property (
    trig_hit && next_q.on && !q.go |=> q.go)
    else $error("trigger with converter on did not start");

  a_trig_off_ignored: assert property (
    trig_hit && !next_q.on && !q.go |=> !q.go)
    else $error("trigger started a conversion while off");

  a_trig_timer_reset: assert property (
    trig_hit |=> timer_reset)
    else $error("trigger did not reset the timer");

  a_off_never_busy: assert property (
    !q.on |-> !q.go)
    else $error("start bit set while converter off");

  a_analog_reads_zero: assert property (
    q.bus == adcc_pkg::ADCC_BUS_RWAIT && q.dp_idx == `ADCC_IDX_PORT_A
    |=> (q.hrdata[5:0] & analog_mask(q.pcfg)) == 6'h00)
    else $error("analog pin read as nonzero");

  // =============================================================
  // flag, start refusal, trigger, trial code, interrupt and tick spacing checks, and covers
  a_flag_sw_clear: assert property (
    $fell(q.irq_flag) |-> $past(q.bus) == adcc_pkg::ADCC_BUS_WRITE
                          && $past(q.dp_idx) == `ADCC_IDX_IRQ_FLAGS)
    else $error("conversion flag cleared without a software write");

  a_go_refused_off: assert property (
    q.bus == adcc_pkg::ADCC_BUS_WRITE && q.dp_idx == `ADCC_IDX_CTRL0 && !q.on && !trig_hit
    |=> !q.go)
    else $error("start accepted in the write that turns the converter on");

  a_timer_from_trig: assert property (
    timer_reset |-> $past(trig_hit))
    else $error("timer reset without a trigger");

  a_trig_needs_mode: assert property (
    special_event_trig && compare_mode_field != `ADCC_CMP_TRIG_MODE |=> !timer_reset)
    else $error("trigger outside special event mode reset the timer");

  a_idle_trial_zero: assert property (
    !q.go && !$past(q.go) |-> sar_trial == 8'h00)
    else $error("trial code shown while idle");

  a_first_trial: assert property (
    q.go && next_q.go && half_tick && cnt_n == `ADCC_SAMPLE_HALVES
    |=> sar_trial == 8'h80)
    else $error("first trial code is not the top bit");

  a_irq_level: assert property (
    irq_request == (q.irq_flag && q.irq_en && q.intctl[`ADCC_PERIPHERAL_IRQ_ENABLE_BIT]
                    && q.intctl[`ADCC_GIE_BIT]))
    else $error("interrupt request does not follow flag and enables");

  a_div32_spacing: assert property (
    half_tick && q.go && q.clk_sel == adcc_pkg::ADCC_DIV32 |=> !half_tick[*8])
    else $error("half ticks too close under divide by thirty-two");

  c_conv_done:  cover property (q.done);
  c_trig_start: cover property (trig_hit && q.on && !q.go);
  c_set_wins:   cover property (q.done && $past(q.bus == adcc_pkg::ADCC_BUS_WRITE)
                                && $past(q.dp_idx) == `ADCC_IDX_IRQ_FLAGS);
  c_rc_done:    cover property (q.done && q.clk_sel == adcc_pkg::ADCC_RC);
  c_abort:      cover property ($fell(q.go) && !q.done);

endmodule : adcc_top

// *** tb/adcc_comp_model.sv ***
// comparator and rc oscillator standing in for the analog side of the converter
module adcc_comp_model #(
  parameter int RC_HALF_NS = 2000
) (
  input  wire logic [7:0] sar_trial,
  input  wire logic [7:0] pin_level,
  output logic            comp_above,
  output logic            rc_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // =============================================================
  // comparator: the level converted is whatever the pin carries, driven or not
  assign comp_above = (pin_level >= sar_trial);
  // =============================================================
  // free-running rc source, offset so its edges never meet hclk edges
  initial begin
    rc_clk = 1'h0;
    #3;
    forever #(RC_HALF_NS) rc_clk = ~rc_clk;
  end
endmodule : adcc_comp_model

// *** tb/test_adc_conversion_control.sv ***
// self-checking bench for the converter control block
`include "adcc_cfg.svh"

module test_adc_conversion_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TIMEOUT_CYCLES = 20000;
  // acquisition time (arbitrary) plus two rc bit periods, the longest gap software owes
  localparam int SETTLE_CYCLES  = 900;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [5:0]  port_a_in, port_a_out, port_a_oe;
  logic [3:0]  compare_mode_field;
  logic        rc_clk, special_event_trig, timer_reset, comp_above, conv_busy, irq_request;
  logic [2:0]  conv_channel;
  logic [7:0]  sar_trial, pin_level;
  int          n_errors, checks, cycles;

  adcc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_a_in(port_a_in),
    .port_a_out(port_a_out), .port_a_oe(port_a_oe), .rc_clk(rc_clk),
    .compare_mode_field(compare_mode_field), .special_event_trig(special_event_trig),
    .timer_reset(timer_reset), .conv_channel(conv_channel), .sar_trial(sar_trial),
    .comp_above(comp_above), .conv_busy(conv_busy), .irq_request(irq_request));

  adcc_comp_model i_far (.sar_trial(sar_trial), .pin_level(pin_level),
    .comp_above(comp_above), .rc_clk(rc_clk));

  // =============================================================
  // checking and bus helpers
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // address phase held until hready, then data phase held until hready again
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'h1, idx, d, r);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    xfer(1'h0, idx, 8'h00, r);
    chk(r, {24'h0, exp});
    chk({31'h0, hresp}, 32'h0);
  endtask : rdc

  function automatic logic [7:0] ctl(input int sel, input int ch, input logic go);
    return {2'(sel), 3'(ch), go, 1'h0, 1'h1};
  endfunction : ctl

  // cycles for which conv_busy stays high, waiting a bounded time for it to rise
  task automatic conv_time(output int n);
    int w;
    w = 0;
    n = 0;
    while (conv_busy !== 1'h1 && w < 100) begin
      @(posedge hclk);
      w++;
    end
    while (conv_busy === 1'h1 && n < 5000) begin
      @(posedge hclk);
      n++;
    end
  endtask : conv_time

  // channel settling before a start, and the gap after a finished conversion
  task automatic acq_wait;
    repeat (SETTLE_CYCLES) @(posedge hclk);
  endtask : acq_wait

  task automatic pulse_trig(input logic [3:0] mode, input int exp);
    int k;
    compare_mode_field <= mode;
    @(posedge hclk);
    special_event_trig <= 1'h1;
    @(posedge hclk);
    special_event_trig <= 1'h0;
    k = 0;
    repeat (4) begin
      @(posedge hclk);
      if (timer_reset === 1'h1) k++;
    end
    chk(32'(k), 32'(exp));
  endtask : pulse_trig

  // =============================================================
  // scenarios
  task automatic test_reset_regs;
    chk({31'h0, conv_busy}, 32'h0);
    rdc(`ADCC_IDX_CTRL0, 8'h00);
    rdc(`ADCC_IDX_PIN_CFG, 8'h00);
    rdc(`ADCC_IDX_PORT_DIR, 8'h3f);
    rdc(`ADCC_IDX_IRQ_FLAGS, 8'h00);
    rdc(`ADCC_IDX_IRQ_ENS, 8'h00);
    rdc(`ADCC_IDX_RESULT, 8'h00);
    wr(`ADCC_IDX_NONE, 8'h5a);
    rdc(`ADCC_IDX_NONE, 8'h00);
    wr(`ADCC_IDX_RESULT, 8'h77);
    rdc(`ADCC_IDX_RESULT, 8'h00);
  endtask : test_reset_regs

  // every clock select code, with completion seen by polling and by the interrupt line
  task automatic test_conv_clocks;
    int n;
    wr(`ADCC_IDX_IRQ_FLAGS, 8'h00);
    wr(`ADCC_IDX_IRQ_ENS, 8'h40);
    wr(`ADCC_IDX_INTCTL, 8'hc0);
    for (int s = 0; s < 4; s++) begin
      pin_level <= 8'h5a + 8'(s * 37);
      wr(`ADCC_IDX_CTRL0, ctl(s, s + 1, 1'h0));
      acq_wait();
      wr(`ADCC_IDX_CTRL0, ctl(s, s + 1, 1'h1));
      chk({29'h0, conv_channel}, 32'(s + 1));
      conv_time(n);
      // rc is run awake only to time it; sleep is outside this bench
      if (s < 3)
        chk(32'(n), 32'(19 * (1 << (2 * s)) + 1));
      else
        chk({31'h0, (n >= 3600 && n <= 3810)}, 32'h1);
      chk({31'h0, irq_request}, 32'h1);
      rdc(`ADCC_IDX_RESULT, 8'h5a + 8'(s * 37));
      chk({24'h0, sar_trial}, 32'h0);
      rdc(`ADCC_IDX_CTRL0, ctl(s, s + 1, 1'h0));
      rdc(`ADCC_IDX_IRQ_FLAGS, 8'h40);
      wr(`ADCC_IDX_IRQ_FLAGS, 8'h00);
      rdc(`ADCC_IDX_IRQ_FLAGS, 8'h00);
      chk({31'h0, irq_request}, 32'h0);
    end
  endtask : test_conv_clocks

  // go in the turn-on write is ignored, and a cleared go aborts a conversion
  task automatic test_go_refused;
    wr(`ADCC_IDX_CTRL0, 8'h00);
    wr(`ADCC_IDX_CTRL0, 8'h85);
    repeat (5) @(posedge hclk);
    chk({31'h0, conv_busy}, 32'h0);
    rdc(`ADCC_IDX_CTRL0, 8'h81);
    pin_level <= 8'h11;
    acq_wait();
    wr(`ADCC_IDX_CTRL0, 8'h85);
    wr(`ADCC_IDX_CTRL0, 8'h81);
    repeat (3) @(posedge hclk);
    chk({31'h0, conv_busy}, 32'h0);
    rdc(`ADCC_IDX_RESULT, 8'h5a + 8'(3 * 37));
    rdc(`ADCC_IDX_IRQ_FLAGS, 8'h00);
  endtask : test_go_refused

  // trigger ignored while off, taken while on, with an out-of-range channel and output pins
  task automatic test_trigger;
    int n;
    pin_level <= 8'hc3;
    wr(`ADCC_IDX_PORT_DIR, 8'h00);
    wr(`ADCC_IDX_CTRL0, 8'h38);
    pulse_trig(4'hb, 1);
    chk({31'h0, conv_busy}, 32'h0);
    wr(`ADCC_IDX_CTRL0, 8'h39);
    pulse_trig(4'h3, 0);
    chk({31'h0, conv_busy}, 32'h0);
    acq_wait();
    pulse_trig(4'hb, 1);
    chk({31'h0, conv_busy}, 32'h1);
    conv_time(n);
    rdc(`ADCC_IDX_RESULT, 8'hc3);
    rdc(`ADCC_IDX_IRQ_FLAGS, 8'h40);
    wr(`ADCC_IDX_IRQ_FLAGS, 8'h00);
  endtask : test_trigger

  task automatic test_ports;
    port_a_in <= 6'h3f;
    wr(`ADCC_IDX_PIN_CFG, 8'h00);
    rdc(`ADCC_IDX_PORT_A, 8'h10);
    wr(`ADCC_IDX_PIN_CFG, 8'h04);
    rdc(`ADCC_IDX_PORT_A, 8'h34);
    wr(`ADCC_IDX_PIN_CFG, 8'h06);
    rdc(`ADCC_IDX_PORT_A, 8'h3f);
    wr(`ADCC_IDX_PORT_DIR, 8'h0f);
    wr(`ADCC_IDX_PORT_A, 8'h2a);
    // the latch takes the write at the edge the task returns on
    @(posedge hclk);
    chk({26'h0, port_a_oe}, 32'h30);
    chk({26'h0, port_a_out}, 32'h2a);
  endtask : test_ports

  // =============================================================
  // clock, watchdog and main sequence
  initial begin
    hclk = 1'h0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles >= TIMEOUT_CYCLES) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    port_a_in = 6'h00;
    compare_mode_field = 4'h0;
    special_event_trig = 1'h0;
    pin_level = 8'h00;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    test_reset_regs();
    test_conv_clocks();
    test_go_refused();
    test_trigger();
    test_ports();
    tally_and_finish();
  end
endmodule : test_adc_conversion_control
